// ### logic/cmb_buffer_control.sv
// cmb_buffer_control: pair control registers, full/overflow flags, transmit offer and
// receive store burst for eight CAN message buffers held in system RAM.
// assumes an Avalon-MM master on sys_clk and a protocol engine on the same clock.
//
// Chosen here: the register offsets and the Avalon-MM register port.
module cmb_buffer_control
    import cmb_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic [ADDR_W-1:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWriteData,
    input wire logic [3:0] avsByteEnable,
    output logic [31:0] avsReadData,
    output logic avsWaitRequest,
    input cmbTxEvt_t txEvt,
    input cmbSel_t remoteEvt,
    input wire logic rxStoreValid,
    input wire logic [BUF_IDX_W-1:0] rxStoreIdx,
    input cmbRxFrame_t rxFrame,
    output logic rxReady,
    output cmbSel_t txOffer,
    output cmbSel_t txAbort,
    output cmbRamWr_t ramWr,
    output logic [NUM_BUF-1:0] bufIsTx
);
    typedef struct packed {
        cmbCtl_t [NUM_BUF-1:0] ctl;
        logic [NUM_BUF-1:0] full;
        logic [NUM_BUF-1:0] ovf;
        logic waitReq;
        logic [31:0] rdData;
        cmbSel_t offer;
        cmbSel_t abortOut;
        cmbStore_t store;
        logic [BUF_IDX_W-1:0] storeBuf;
        logic [WORD_IDX_W-1:0] wordIdx;
        cmbWords_t words;
        cmbRamWr_t ram;
        logic ready;
    } cmbState_t;

    cmbState_t state_q;
    cmbState_t state_d;
    cmbWords_t packed_w;
    cmbSel_t pick;
    logic [NUM_BUF-1:0] pending;
    logic [NUM_BUF-1:0][1:0] prio;
    logic busReq;
    logic doAccess;
    logic ctlHit;
    logic storeAccept;
    logic [1:0] ctlReg;
    cmbCtl_t wrByte;
    logic [BUF_IDX_W-1:0] bufSel;

    assign busReq = avsRead | avsWrite;
    assign doAccess = busReq & ~state_q.waitReq;
    assign ctlHit = ~avsAddress[CTL_SEL_BIT];
    assign ctlReg = avsAddress[3:2];
    assign storeAccept = rxStoreValid & state_q.ready;

    always_comb begin
        for (int i = 0; i < NUM_BUF; i++) begin
            pending[i] = state_q.ctl[i].dir & state_q.ctl[i].sendReq;
            prio[i] = state_q.ctl[i].transmitPriority;
        end
    end

    cmb_tx_arbiter u_arb (
        .pending(pending),
        .transmitPriority(prio),
        .pick(pick)
    );

    cmb_msg_pack u_pack (
        .frame(rxFrame),
        .words(packed_w)
    );

    always_comb begin
        state_d = state_q;
        wrByte = '0;
        bufSel = '0;
        state_d.abortOut = '0;

        // one wait state: request seen, then answered on the following edge
        state_d.waitReq = ~(busReq & state_q.waitReq);
        if (busReq && state_q.waitReq) begin
            state_d.rdData = '0;
            if (ctlHit) begin
                state_d.rdData[15:0] = {state_q.ctl[{ctlReg, 1'b1}], state_q.ctl[{ctlReg, 1'b0}]};
            end else if (avsAddress[ADDR_W-1:2] == ADDR_FULL[ADDR_W-1:2]) begin
                state_d.rdData[NUM_BUF-1:0] = state_q.full;
            end else if (avsAddress[ADDR_W-1:2] == ADDR_OVF[ADDR_W-1:2]) begin
                state_d.rdData[NUM_BUF-1:0] = state_q.ovf;
            end else if (avsAddress[ADDR_W-1:2] == ADDR_STAT[ADDR_W-1:2]) begin
                state_d.rdData[7:0] = {3'h0, state_q.store == ST_WRITE, state_q.offer};
            end
        end

        // software writes: clears and set-request happen first so hardware events win
        if (doAccess && avsWrite) begin
            if (ctlHit) begin
                for (int b = 0; b < 2; b++) begin
                    if (avsByteEnable[b]) begin
                        bufSel = {ctlReg, b[0]};
                        wrByte = cmbCtl_t'(avsWriteData[8*b +: 8]);
                        state_d.ctl[bufSel].dir = wrByte.dir;
                        state_d.ctl[bufSel].autoRemote = wrByte.autoRemote;
                        state_d.ctl[bufSel].transmitPriority = wrByte.transmitPriority;
                        state_d.ctl[bufSel].sendReq = wrByte.sendReq;
                        if (wrByte.sendReq && !state_q.ctl[bufSel].sendReq) begin
                            state_d.ctl[bufSel].aborted = 1'b0;
                            state_d.ctl[bufSel].arbLost = 1'b0;
                            state_d.ctl[bufSel].txErr = 1'b0;
                        end
                        if (!wrByte.sendReq && state_q.ctl[bufSel].sendReq) begin
                            state_d.ctl[bufSel].aborted = 1'b1;
                            state_d.abortOut.valid = 1'b1;
                            state_d.abortOut.idx = bufSel;
                        end
                    end
                end
            end else if (avsAddress[ADDR_W-1:2] == ADDR_FULL[ADDR_W-1:2] && avsByteEnable[0]) begin
                state_d.full = state_q.full & avsWriteData[NUM_BUF-1:0];
            end else if (avsAddress[ADDR_W-1:2] == ADDR_OVF[ADDR_W-1:2] && avsByteEnable[0]) begin
                state_d.ovf = state_q.ovf & avsWriteData[NUM_BUF-1:0];
            end
        end

        // transmit outcome from the protocol engine
        if (txEvt.done) begin
            state_d.ctl[txEvt.idx].sendReq = 1'b0;
            state_d.ctl[txEvt.idx].aborted = 1'b0;
        end
        if (txEvt.arbLost) begin
            state_d.ctl[txEvt.idx].arbLost = 1'b1;
        end
        if (txEvt.busErr) begin
            state_d.ctl[txEvt.idx].txErr = 1'b1;
        end
        // remote frame answered automatically; a set beats the completion clear
        if (remoteEvt.valid && state_q.ctl[remoteEvt.idx].autoRemote) begin
            state_d.ctl[remoteEvt.idx].sendReq = 1'b1;
        end

        state_d.offer = pick;

        // receive store burst into RAM, only for receive buffers
        state_d.ram.valid = 1'b0;
        unique case (state_q.store)
            ST_IDLE: begin
                if (storeAccept && !state_q.ctl[rxStoreIdx].dir) begin
                    if (state_q.full[rxStoreIdx]) begin
                        state_d.ovf[rxStoreIdx] = 1'b1;
                    end else begin
                        state_d.store = ST_WRITE;
                        state_d.storeBuf = rxStoreIdx;
                        state_d.words = packed_w;
                        state_d.wordIdx = '0;
                        state_d.ram.valid = 1'b1;
                        state_d.ram.addr = {rxStoreIdx, {WORD_IDX_W{1'b0}}};
                        state_d.ram.data = packed_w[0];
                    end
                end
            end
            ST_WRITE: begin
                if (state_q.wordIdx == WORD_LAST) begin
                    state_d.store = ST_IDLE;
                    state_d.full[state_q.storeBuf] = 1'b1;
                end else begin
                    state_d.wordIdx = state_q.wordIdx + 1'b1;
                    state_d.ram.valid = 1'b1;
                    state_d.ram.addr = {state_q.storeBuf, state_d.wordIdx};
                    state_d.ram.data = state_q.words[state_d.wordIdx];
                end
            end
        endcase
        state_d.ready = (state_d.store == ST_IDLE);
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= '0;
            state_q.ctl <= {NUM_BUF/2{CTL_RESET}};
            state_q.waitReq <= 1'b1;
            state_q.store <= ST_IDLE;
            state_q.ready <= 1'b1;
        end else begin
            state_q <= state_d;
        end
    end

    assign avsReadData = state_q.rdData;
    assign avsWaitRequest = state_q.waitReq;
    assign rxReady = state_q.ready;
    assign txOffer = state_q.offer;
    assign txAbort = state_q.abortOut;
    assign ramWr = state_q.ram;
    always_comb begin
        for (int i = 0; i < NUM_BUF; i++) begin
            bufIsTx[i] = state_q.ctl[i].dir;
        end
    end

    // checks follow whichever buffer each event names, and the even buffer of each control write
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    logic [NUM_BUF-1:0] swWr;
    logic [BUF_IDX_W-1:0] evenBuf;
    logic [BUF_IDX_W-1:0] oddBuf;
    logic swSetEven;
    logic swAbortEven;
    logic higherWaiting;

    assign evenBuf = {ctlReg, 1'b0};
    assign oddBuf = {ctlReg, 1'b1};
    assign swSetEven = swWr[evenBuf] & avsWriteData[3] & ~state_q.ctl[evenBuf].sendReq;
    assign swAbortEven = swWr[evenBuf] & ~avsWriteData[3] & state_q.ctl[evenBuf].sendReq;

    always_comb begin
        higherWaiting = 1'b0;
        for (int i = 0; i < NUM_BUF; i++) begin
            swWr[i] = doAccess & avsWrite & ctlHit & (ctlReg == i[2:1]) & avsByteEnable[i[0]];
            // a waiting buffer that outranks the pick, by priority then by number
            if (pending[i] && (prio[i] > prio[pick.idx]
                    || (prio[i] == prio[pick.idx] && BUF_IDX_W'(i) > pick.idx))) begin
                higherWaiting = 1'b1;
            end
        end
    end

    property p_doneClears;
        txEvt.done && !swWr[txEvt.idx] && !(remoteEvt.valid && remoteEvt.idx == txEvt.idx)
            |=> !state_q.ctl[$past(txEvt.idx)].sendReq && !state_q.ctl[$past(txEvt.idx)].aborted;
    endproperty
    a_doneClears: assert property (p_doneClears) else $error("send request not cleared after success");

    property p_abortWrite;
        swAbortEven && !swWr[oddBuf] && !(txEvt.done && txEvt.idx == evenBuf)
            |=> state_q.ctl[$past(evenBuf)].aborted && txAbort.valid && txAbort.idx == $past(evenBuf)
            ##1 !txAbort.valid;
    endproperty
    a_abortWrite: assert property (p_abortWrite) else $error("abort not raised on clearing request");

    property p_setClearsFlags;
        swSetEven && !(txEvt.idx == evenBuf && (txEvt.done || txEvt.arbLost || txEvt.busErr))
            |=> state_q.ctl[$past(evenBuf)].sendReq && !state_q.ctl[$past(evenBuf)].arbLost
            && !state_q.ctl[$past(evenBuf)].txErr;
    endproperty
    a_setClearsFlags: assert property (p_setClearsFlags) else $error("setting request kept old flags");

    property p_remoteOn;
        remoteEvt.valid && state_q.ctl[remoteEvt.idx].autoRemote
            |=> state_q.ctl[$past(remoteEvt.idx)].sendReq;
    endproperty
    a_remoteOn: assert property (p_remoteOn) else $error("remote frame did not set request");

    property p_remoteOff;
        remoteEvt.valid && !state_q.ctl[remoteEvt.idx].autoRemote && !swWr[remoteEvt.idx]
            && !(txEvt.done && txEvt.idx == remoteEvt.idx)
            |=> state_q.ctl[$past(remoteEvt.idx)].sendReq == $past(state_q.ctl[remoteEvt.idx].sendReq);
    endproperty
    a_remoteOff: assert property (p_remoteOff) else $error("remote frame changed request while off");

    property p_lostFlag;
        txEvt.arbLost |=> state_q.ctl[$past(txEvt.idx)].arbLost;
    endproperty
    a_lostFlag: assert property (p_lostFlag) else $error("arbitration loss not flagged");

    property p_errFlag;
        txEvt.busErr |=> state_q.ctl[$past(txEvt.idx)].txErr;
    endproperty
    a_errFlag: assert property (p_errFlag) else $error("bus error not flagged");

    property p_overflow;
        storeAccept && !state_q.ctl[rxStoreIdx].dir && state_q.full[rxStoreIdx]
            |=> state_q.ovf[$past(rxStoreIdx)] && !ramWr.valid;
    endproperty
    a_overflow: assert property (p_overflow) else $error("store into full buffer not flagged");

    property p_dropTx;
        storeAccept && state_q.ctl[rxStoreIdx].dir |=> !ramWr.valid && rxReady;
    endproperty
    a_dropTx: assert property (p_dropTx) else $error("frame stored into a transmit buffer");

    property p_storeBurst;
        storeAccept && !state_q.ctl[rxStoreIdx].dir && !state_q.full[rxStoreIdx]
            |=> ramWr.valid [*8] ##1 !ramWr.valid && state_q.full[$past(rxStoreIdx, 9)] && rxReady;
    endproperty
    a_storeBurst: assert property (p_storeBurst) else $error("store burst length or full flag wrong");

    property p_offerBest;
        txOffer.valid |-> |($past(pending) & (NUM_BUF'(1) << txOffer.idx));
    endproperty
    a_offerBest: assert property (p_offerBest) else $error("offered buffer was not pending transmit");

    property p_pickBest;
        (|pending) |-> pick.valid && pending[pick.idx] && !higherWaiting;
    endproperty
    a_pickBest: assert property (p_pickBest) else $error("arbiter passed over a better buffer");

    property p_waitOne;
        busReq && avsWaitRequest |=> !avsWaitRequest;
    endproperty
    a_waitOne: assert property (p_waitOne) else $error("bus answer not after one wait state");

    property p_waitStands;
        !avsWaitRequest |=> avsWaitRequest;
    endproperty
    a_waitStands: assert property (p_waitStands) else $error("bus answer held longer than one cycle");
endmodule : cmb_buffer_control

// ### logic/cmb_pkg.sv
// cmb_pkg: constants, register map and carrier types for the CAN message buffer control block.
// assumes a single 100 MHz system clock shared by the bus slave and the protocol engine.
package cmb_pkg;
    localparam int NUM_BUF = 8;
    localparam int BUF_IDX_W = 3;
    localparam int WORDS_PER_BUF = 8;
    localparam int WORD_IDX_W = 3;
    localparam int RAM_ADDR_W = BUF_IDX_W + WORD_IDX_W;
    localparam int ADDR_W = 5;
    localparam int DATA_BYTES = 8;

    // byte addresses of the Avalon register window
    localparam logic [ADDR_W-1:0] ADDR_FULL = 5'h10;
    localparam logic [ADDR_W-1:0] ADDR_OVF = 5'h14;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 5'h18;
    localparam int CTL_SEL_BIT = 4;
    localparam logic [15:0] CTL_RESET = 16'h0000;

    localparam logic [2:0] WORD_LAST = 3'h7;

    // one control byte, bit 7 down to bit 0
    typedef struct packed {
        logic dir;
        logic aborted;
        logic arbLost;
        logic txErr;
        logic sendReq;
        logic autoRemote;
        logic [1:0] transmitPriority;
    } cmbCtl_t;

    typedef struct packed {
        logic done;
        logic arbLost;
        logic busErr;
        logic [BUF_IDX_W-1:0] idx;
    } cmbTxEvt_t;

    typedef struct packed {
        logic valid;
        logic [BUF_IDX_W-1:0] idx;
    } cmbSel_t;

    typedef struct packed {
        logic valid;
        logic [RAM_ADDR_W-1:0] addr;
        logic [15:0] data;
    } cmbRamWr_t;

    typedef struct packed {
        logic ide;
        logic rtr;
        logic [10:0] sid;
        logic [17:0] eid;
        logic [3:0] dlc;
        logic [DATA_BYTES-1:0][7:0] data;
        logic [4:0] filterHit;
    } cmbRxFrame_t;

    typedef logic [WORDS_PER_BUF-1:0][15:0] cmbWords_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_WRITE = 1'b1
    } cmbStore_t;
endpackage : cmb_pkg

// ### logic/cmb_tx_arbiter.sv
// cmb_tx_arbiter: picks the pending transmit buffer to offer to the protocol engine.
// assumes pending flags and priorities come from registers on the same clock.
module cmb_tx_arbiter
    import cmb_pkg::*;
(
    input wire logic [NUM_BUF-1:0] pending,
    input wire logic [NUM_BUF-1:0][1:0] transmitPriority,
    output cmbSel_t pick
);
    logic [1:0] bestPri;

    // ascending scan with >= lets the higher buffer number win a tie
    always_comb begin
        pick = '0;
        bestPri = '0;
        for (int i = 0; i < NUM_BUF; i++) begin
            if (pending[i] && (!pick.valid || transmitPriority[i] >= bestPri)) begin
                pick.valid = 1'b1;
                pick.idx = BUF_IDX_W'(i);
                bestPri = transmitPriority[i];
            end
        end
    end
endmodule : cmb_tx_arbiter

// ### logic/cmb_msg_pack.sv
// cmb_msg_pack: lays a received frame out as the eight 16-bit words of a message buffer.
// assumes the frame fields are already decoded by the protocol engine.
module cmb_msg_pack
    import cmb_pkg::*;
(
    input cmbRxFrame_t frame,
    output cmbWords_t words
);
    localparam int DATA_WORD0 = 3;

    always_comb begin
        words = '0;
        // extended frames carry SRR as one, standard frames carry the remote flag there
        words[0] = {3'h0, frame.sid, frame.ide ? 1'b1 : frame.rtr, frame.ide};
        words[1] = {4'h0, frame.eid[17:6]};
        // RTR only meaningful for extended ids; reserved bits stay zero
        words[2] = {frame.eid[5:0], frame.ide & frame.rtr, 1'b0, 3'h0, 1'b0, frame.dlc};
        for (int k = 0; k < DATA_BYTES / 2; k++) begin
            words[DATA_WORD0 + k] = {frame.data[2*k+1], frame.data[2*k]};
        end
        words[WORD_LAST] = {3'h0, frame.filterHit, 8'h00};
    end
endmodule : cmb_msg_pack

// ### bench/cmb_engine_model.sv
// cmb_engine_model: protocol engine and system RAM as seen from the buffer control block.
// assumes the bench issues one-cycle commands on sys_clk; RAM words are read hierarchically.
module cmb_engine_model
    import cmb_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic cmdTx,
    input wire logic [1:0] cmdKind,
    input wire logic cmdRemote,
    input wire logic cmdStore,
    input wire logic [BUF_IDX_W-1:0] cmdIdx,
    input cmbRxFrame_t cmdFrame,
    input cmbSel_t txOffer,
    input wire logic rxReady,
    input cmbRamWr_t ramWr,
    output cmbTxEvt_t txEvt,
    output cmbSel_t remoteEvt,
    output logic rxStoreValid,
    output logic [BUF_IDX_W-1:0] rxStoreIdx,
    output cmbRxFrame_t rxFrame
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] ram [64];

    initial begin
        for (int i = 0; i < 64; i++) begin
            ram[i] = 16'h0000;
        end
    end

    // buffer words live here, software reads them directly
    always @(posedge sys_clk) begin
        if (ramWr.valid === 1'b1) begin
            ram[ramWr.addr] <= ramWr.data;
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            txEvt <= '0;
            remoteEvt <= '0;
            rxStoreValid <= 1'b0;
            rxStoreIdx <= '0;
            rxFrame <= '0;
        end else begin
            txEvt <= '0;
            remoteEvt <= '0;
            if (cmdTx) begin
                // outcome of the frame currently offered: 0 sent, 1 lost arbitration, 2 bus error
                txEvt.done <= (cmdKind == 2'h0);
                txEvt.arbLost <= (cmdKind == 2'h1);
                txEvt.busErr <= (cmdKind == 2'h2);
                txEvt.idx <= txOffer.idx;
            end
            if (cmdRemote) begin
                remoteEvt.valid <= 1'b1;
                remoteEvt.idx <= cmdIdx;
            end
            if (cmdStore) begin
                rxStoreValid <= 1'b1;
                rxStoreIdx <= cmdIdx;
                rxFrame <= cmdFrame;
            end else if (rxStoreValid && rxReady) begin
                // released lines no longer show the stored frame
                rxStoreValid <= 1'b0;
                rxStoreIdx <= ~rxStoreIdx;
                rxFrame <= cmbRxFrame_t'(~rxFrame);
            end
        end
    end
endmodule : cmb_engine_model

// ### bench/cmb_buffer_control_bench.sv
// cmb_buffer_control_bench: register, transmit-event and receive-store checks of the buffer control.
// assumes one wait state per Avalon access and an engine model that stores words in its RAM.
module cmb_buffer_control_bench
    import cmb_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk;
    logic sys_rst;
    logic [ADDR_W-1:0] avsAddress;
    logic avsRead;
    logic avsWrite;
    logic [31:0] avsWriteData;
    logic [31:0] avsReadData;
    logic [31:0] rd;
    logic [3:0] avsByteEnable;
    logic avsWaitRequest;
    logic rxReady;
    logic rxStoreValid;
    logic cmdTx;
    logic cmdRemote;
    logic cmdStore;
    logic [1:0] cmdKind;
    logic [BUF_IDX_W-1:0] cmdIdx;
    logic [BUF_IDX_W-1:0] rxStoreIdx;
    logic [BUF_IDX_W-1:0] abortIdx;
    logic [NUM_BUF-1:0] bufIsTx;
    cmbRxFrame_t cmdFrame;
    cmbRxFrame_t rxFrame;
    cmbRxFrame_t frA;
    cmbRxFrame_t frB;
    cmbTxEvt_t txEvt;
    cmbSel_t remoteEvt;
    cmbSel_t txOffer;
    cmbSel_t txAbort;
    cmbRamWr_t ramWr;
    int miscompares;
    int cmp_count;
    int abortCnt;

    cmb_buffer_control cmb_buffer_control_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
        .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .txEvt(txEvt), .remoteEvt(remoteEvt),
        .rxStoreValid(rxStoreValid), .rxStoreIdx(rxStoreIdx), .rxFrame(rxFrame), .rxReady(rxReady),
        .txOffer(txOffer), .txAbort(txAbort), .ramWr(ramWr), .bufIsTx(bufIsTx));
    cmb_engine_model cmb_engine_model_inst (.sys_clk(sys_clk), .sys_rst(sys_rst), .cmdTx(cmdTx),
        .cmdKind(cmdKind), .cmdRemote(cmdRemote), .cmdStore(cmdStore), .cmdIdx(cmdIdx), .cmdFrame(cmdFrame),
        .txOffer(txOffer), .rxReady(rxReady), .ramWr(ramWr), .txEvt(txEvt), .remoteEvt(remoteEvt),
        .rxStoreValid(rxStoreValid), .rxStoreIdx(rxStoreIdx), .rxFrame(rxFrame));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        if (txAbort.valid === 1'b1) begin
            abortCnt++;
            abortIdx = txAbort.idx;
        end
    end

    task summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize

    task check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task busAccess(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] be);
        int n;
        @(posedge sys_clk);
        avsAddress <= a;
        avsWrite <= wr;
        avsRead <= !wr;
        avsWriteData <= d;
        avsByteEnable <= be;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avsWaitRequest !== 1'b0 && n < 50);
        if (avsWaitRequest !== 1'b0) begin
            miscompares++;
            summarize();
        end
        rd = avsReadData;
        avsWrite <= 1'b0;
        avsRead <= 1'b0;
    endtask : busAccess

    task rdCheck(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
        busAccess(1'b0, a, 32'h0, 4'hf);
        check(rd, exp);
    endtask : rdCheck

    task chkOffer(input logic [3:0] exp);
        rdCheck(ADDR_STAT, {28'h0, exp});
        check({28'h0, txOffer}, {28'h0, exp});
    endtask : chkOffer

    // kind 0 sent, 1 lost arbitration, 2 bus error; remote raises a remote frame for buffer i
    task engine(input logic [1:0] k, input logic remote, input logic [BUF_IDX_W-1:0] i);
        @(posedge sys_clk);
        cmdTx <= !remote;
        cmdRemote <= remote;
        cmdKind <= k;
        cmdIdx <= i;
        @(posedge sys_clk);
        cmdTx <= 1'b0;
        cmdRemote <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask : engine

    task store(input logic [BUF_IDX_W-1:0] i, input cmbRxFrame_t f);
        int n;
        @(posedge sys_clk);
        cmdStore <= 1'b1;
        cmdIdx <= i;
        cmdFrame <= f;
        @(posedge sys_clk);
        cmdStore <= 1'b0;
        @(posedge sys_clk);
        n = 0;
        while ((rxStoreValid !== 1'b0 || rxReady !== 1'b1) && n < 40) begin
            @(posedge sys_clk);
            n++;
        end
        if (n == 40) begin
            miscompares++;
            summarize();
        end
        repeat (2) @(posedge sys_clk);
    endtask : store

    function automatic logic [15:0] expWord(input cmbRxFrame_t f, input int w);
        case (w)
            0: return {3'h0, f.sid, f.ide | f.rtr, f.ide};
            1: return {4'h0, f.eid[17:6]};
            2: return {f.eid[5:0], f.ide & f.rtr, 1'b0, 3'h0, 1'b0, f.dlc};
            7: return {3'h0, f.filterHit, 8'h00};
            default: return {f.data[2*w-5], f.data[2*w-6]};
        endcase
    endfunction : expWord

    task checkRam(input int b, input cmbRxFrame_t f);
        for (int w = 0; w < 8; w++) begin
            check({16'h0, cmb_engine_model_inst.ram[b*8+w]}, {16'h0, expWord(f, w)});
        end
    endtask : checkRam

    initial begin
        {avsAddress, avsRead, avsWrite, avsWriteData, avsByteEnable} = '0;
        {cmdTx, cmdRemote, cmdStore, cmdKind, cmdIdx, cmdFrame} = '0;
        miscompares = 0;
        cmp_count = 0;
        abortCnt = 0;
        frA = '{ide: 1'b0, rtr: 1'b1, sid: 11'h5a3, eid: 18'h2bcde, dlc: 4'h8, data: 64'h8877665544332211,
            filterHit: 5'h15};
        frB = '{ide: 1'b1, rtr: 1'b1, sid: 11'h7f1, eid: 18'h2a5c3, dlc: 4'h5, data: 64'h0123456789abcdef,
            filterHit: 5'h1f};
        sys_rst = 1'b1;
        repeat (3) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (int a = 0; a < 28; a += 4) begin
            rdCheck(5'(a), 32'h0);
        end
        busAccess(1'b1, 5'h1c, 32'hffffffff, 4'hf);
        rdCheck(5'h1c, 32'h0);
        busAccess(1'b1, 5'h00, 32'h00008a87, 4'hf);
        busAccess(1'b1, 5'h04, 32'h00008b8b, 4'hf);
        rdCheck(5'h00, 32'h00008a87);
        check({24'h0, bufIsTx}, 32'h0000000f);
        chkOffer(4'hb);
        engine(2'h0, 1'b0, 3'h0);
        rdCheck(5'h04, 32'h0000838b);
        chkOffer(4'ha);
        engine(2'h1, 1'b0, 3'h0);
        rdCheck(5'h04, 32'h000083ab);
        engine(2'h2, 1'b0, 3'h0);
        rdCheck(5'h04, 32'h000083bb);
        busAccess(1'b1, 5'h04, 32'h00000083, 4'h1);
        rdCheck(5'h04, 32'h000083f3);
        check(32'(abortCnt), 32'h1);
        check({29'h0, abortIdx}, 32'h2);
        chkOffer(4'h9);
        busAccess(1'b1, 5'h04, 32'h0000008b, 4'h1);
        rdCheck(5'h04, 32'h0000838b);
        engine(2'h0, 1'b0, 3'h0);
        rdCheck(5'h04, 32'h00008383);
        busAccess(1'b1, 5'h08, 32'h00000080, 4'hf);
        engine(2'h0, 1'b1, 3'h4);
        rdCheck(5'h08, 32'h00000080);
        busAccess(1'b1, 5'h08, 32'h00000084, 4'hf);
        engine(2'h0, 1'b1, 3'h4);
        rdCheck(5'h08, 32'h0000008c);
        store(3'h6, frA);
        checkRam(6, frA);
        rdCheck(ADDR_FULL, 32'h00000040);
        store(3'h7, frB);
        checkRam(7, frB);
        store(3'h6, frB);
        checkRam(6, frA);
        rdCheck(ADDR_OVF, 32'h00000040);
        store(3'h0, frA);
        for (int w = 0; w < 8; w++) begin
            check({16'h0, cmb_engine_model_inst.ram[w]}, 32'h0);
        end
        rdCheck(ADDR_FULL, 32'h000000c0);
        busAccess(1'b1, ADDR_FULL, 32'h0, 4'hf);
        rdCheck(ADDR_FULL, 32'h0);
        busAccess(1'b1, ADDR_OVF, 32'h0, 4'hf);
        rdCheck(ADDR_OVF, 32'h0);
        summarize();
    end
endmodule : cmb_buffer_control_bench
